/* wakeup_pkg.sv */
// shared constants and carrier types for the deep sleep wakeup detector
package wakeup_pkg;

    // ------------------------------------------------------------
    // sizes and timing
    // ------------------------------------------------------------
    localparam int          CLK_PERIOD_NS     = 20;
    localparam int          NUM_IRQ           = 8;
    localparam int          RESTORE_TIME_NS   = 200;
    localparam int          RESTORE_CYCLES    = (RESTORE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          CNT_W             = 8;
    localparam logic [7:0]  CNT_RESET         = 8'h00;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic sleeping;
        logic deep_sleep_select_bit;
        logic debugger_connected;
        logic restore_done;
    } core_status_t;

    typedef struct packed {
        logic power_down_allowed;
        logic wake_request;
        logic tick_stop;
        logic core_clock_stop;
        logic osc_flash_stop;
    } pmu_ctrl_t;

endpackage

/* irq_catch.sv */
// per-line sticky catch of interrupt inputs while armed
module irq_catch #(
    parameter int N = 8
) (
    input  wire logic         mclk,
    input  wire logic         resetn,
    input  wire logic         armed,
    input  wire logic         clear,
    input  wire logic [N-1:0] irq,
    output logic              any_caught
);
    import wakeup_pkg::*;

    logic [N-1:0] caught_reg;
    logic [N-1:0] caught_next;

    // ------------------------------------------------------------
    // catch per line
    // ------------------------------------------------------------
    // set wins clear
    always_comb
    begin
        for (int i = 0; i < N; i++)
        begin
            caught_next[i] = (caught_reg[i] & ~clear) | (armed & irq[i]);
        end
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            caught_reg <= '0;
        else
            caught_reg <= caught_next;
    end

    assign any_caught = |caught_reg;
endmodule

/* deep_sleep_wakeup_detector.sv */
// deep sleep wakeup detector: arms in deep sleep, catches interrupts, drives wake
// Contract
// - an interrupt arriving during deep sleep is sensed and wakes the processor.
// - the detector works only while the deep sleep select bit is 1.
// - there are no software registers; control comes only from hardware signals.
// - the system tick timer is stopped while the core is powered down.
// - waking takes several cycles of restore before the interrupt is serviced.
// - a connected debugger disables the detector.
// - the select bit picks clock-only sleep or deep sleep with oscillators and flash off.
module deep_sleep_wakeup_detector #(
    parameter int NUM_IRQ_P = wakeup_pkg::NUM_IRQ
) (
    input  wire logic                     mclk,
    input  wire logic                     resetn,
    input  wire logic [NUM_IRQ_P-1:0]     irq,
    input  wakeup_pkg::core_status_t      core_status,
    output wakeup_pkg::pmu_ctrl_t         pmu_ctrl,
    output logic                          irq_release
);
    import wakeup_pkg::*;

    typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_WAKE, ST_RESTORE} state_t;

    state_t            state_reg;
    state_t            state_next;
    logic [CNT_W-1:0]  cnt_reg;
    logic [CNT_W-1:0]  cnt_next;
    pmu_ctrl_t         ctrl_reg;
    pmu_ctrl_t         ctrl_next;
    logic              release_reg;
    logic              release_next;
    logic              enable;
    logic              any_caught;
    logic              clear_catch;

    // ------------------------------------------------------------
    // enable
    // ------------------------------------------------------------
    // select bit gates
    // hardware signals only
    // debugger wins over select so a halted core is never powered down
    assign enable = core_status.deep_sleep_select_bit & ~core_status.debugger_connected;
    assign clear_catch = (state_reg == ST_RESTORE) && (cnt_reg == CNT_W'(RESTORE_CYCLES - 1));

    irq_catch #(
        .N          (NUM_IRQ_P)
    ) u_catch (
        .mclk       (mclk),
        .resetn     (resetn),
        .armed      (state_reg == ST_ARMED),
        .clear      (clear_catch),
        .irq        (irq),
        .any_caught (any_caught)
    );

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb
    begin
        state_next   = state_reg;
        cnt_next     = cnt_reg;
        release_next = 1'b0;
        unique case (state_reg)
            ST_IDLE:
            begin
                if (enable && core_status.sleeping)
                    state_next = ST_ARMED;
            end
            ST_ARMED:
            begin
                // caught irq wakes
                // live lines count too, so a one-cycle pulse is never missed
                if (any_caught || (|irq))
                    state_next = ST_WAKE;
                else if (!enable || !core_status.sleeping)
                    state_next = ST_IDLE;
            end
            ST_WAKE:
            begin
                if (core_status.restore_done)
                begin
                    state_next = ST_RESTORE;
                    cnt_next   = CNT_RESET;
                end
            end
            ST_RESTORE:
            begin
                if (cnt_reg == CNT_W'(RESTORE_CYCLES - 1))
                begin
                    state_next   = ST_IDLE;
                    release_next = 1'b1;
                end
                else
                    cnt_next = cnt_reg + 1'b1;
            end
        endcase
    end

    // ------------------------------------------------------------
    // power unit controls
    // ------------------------------------------------------------
    always_comb
    begin
        ctrl_next = '0;
        // sleep depth choice; ordinary sleep only stops the core clock
        ctrl_next.core_clock_stop = core_status.sleeping && (state_next != ST_WAKE)
                                    && (state_next != ST_RESTORE);
        ctrl_next.osc_flash_stop  = (state_next == ST_ARMED);
        ctrl_next.power_down_allowed = (state_next == ST_ARMED);
        ctrl_next.tick_stop = (state_next == ST_ARMED) || (state_next == ST_WAKE);
        ctrl_next.wake_request = (state_next == ST_WAKE);
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_reg   <= ST_IDLE;
            cnt_reg     <= CNT_RESET;
            ctrl_reg    <= '0;
            release_reg <= 1'b0;
        end
        else
        begin
            state_reg   <= state_next;
            cnt_reg     <= cnt_next;
            ctrl_reg    <= ctrl_next;
            release_reg <= release_next;
        end
    end

    assign pmu_ctrl    = ctrl_reg;
    assign irq_release = release_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // restore length kept local so the delay below is a plain constant
    localparam int RESTORE_LEN = RESTORE_CYCLES;

    sequence s_restore_run;
        (state_reg == ST_RESTORE) [*2];
    endsequence

    // first restore cycle: counter cleared and wake request already dropped
    sequence s_restore_start;
        (state_reg == ST_RESTORE) && (cnt_reg == CNT_RESET) && !ctrl_reg.wake_request;
    endsequence

    a_idle_no_power: assert property (@(posedge mclk) disable iff (!resetn)
        !core_status.deep_sleep_select_bit |=> !ctrl_reg.power_down_allowed)
        else $error("power down allowed without deep sleep select");

    a_debug_disarm: assert property (@(posedge mclk) disable iff (!resetn)
        (state_reg == ST_IDLE && core_status.debugger_connected) |=> state_reg == ST_IDLE)
        else $error("armed with debugger connected");

    a_irq_wake: assert property (@(posedge mclk) disable iff (!resetn)
        (state_reg == ST_ARMED && |irq) |=> ctrl_reg.wake_request && state_reg == ST_WAKE)
        else $error("interrupt in deep sleep did not raise wake");

    a_wake_held: assert property (@(posedge mclk) disable iff (!resetn)
        (state_reg == ST_WAKE && !core_status.restore_done) |=> state_reg == ST_WAKE)
        else $error("wake request dropped before restore");

    a_tick_stopped: assert property (@(posedge mclk) disable iff (!resetn)
        (state_reg == ST_ARMED || state_reg == ST_WAKE) |-> ctrl_reg.tick_stop)
        else $error("tick not stopped in deep sleep");

    a_restore_len: assert property (@(posedge mclk) disable iff (!resetn)
        ($rose(state_reg == ST_RESTORE)) |-> ##RESTORE_LEN irq_release)
        else $error("restore did not finish in time");

    a_release_late: assert property (@(posedge mclk) disable iff (!resetn)
        $rose(irq_release) |-> $past(state_reg, 2) == ST_RESTORE)
        else $error("interrupt released without restore");

    a_restore_seq: assert property (@(posedge mclk) disable iff (!resetn)
        ($rose(state_reg == ST_RESTORE) && RESTORE_CYCLES > 1) |-> s_restore_run)
        else $error("restore phase shorter than two cycles");

    a_osc_deep: assert property (@(posedge mclk) disable iff (!resetn)
        ctrl_reg.osc_flash_stop |-> ctrl_reg.core_clock_stop)
        else $error("oscillators stopped without core clock stop");

    // ------------------------------------------------------------
    // arming and restore steps
    // ------------------------------------------------------------
    // the caught flag must outlive power-up, or the waking line is lost
    a_catch_held: assert property (@(posedge mclk) disable iff (!resetn)
        (state_reg == ST_WAKE || state_reg == ST_RESTORE) |-> any_caught)
        else $error("caught interrupt lost before restore");

    a_debug_drop: assert property (@(posedge mclk) disable iff (!resetn)
        (state_reg == ST_ARMED && core_status.debugger_connected && !(|irq) && !any_caught)
        |=> (state_reg == ST_IDLE && !ctrl_reg.power_down_allowed))
        else $error("detector stayed armed with debugger connected");

    a_select_drop: assert property (@(posedge mclk) disable iff (!resetn)
        (state_reg == ST_ARMED && !core_status.deep_sleep_select_bit && !(|irq) && !any_caught)
        |=> (state_reg == ST_IDLE && !ctrl_reg.power_down_allowed))
        else $error("detector stayed armed without deep sleep select");

    a_power_armed: assert property (@(posedge mclk) disable iff (!resetn)
        ctrl_reg.power_down_allowed |-> (state_reg == ST_ARMED) && ctrl_reg.osc_flash_stop)
        else $error("power down allowed outside armed state");

    a_wake_clocks: assert property (@(posedge mclk) disable iff (!resetn)
        ctrl_reg.wake_request |-> ctrl_reg.tick_stop && !ctrl_reg.core_clock_stop
                                  && !ctrl_reg.power_down_allowed)
        else $error("clock controls wrong while waking");

    a_wake_ends: assert property (@(posedge mclk) disable iff (!resetn)
        (state_reg == ST_WAKE && core_status.restore_done) |=> s_restore_start)
        else $error("restore did not start after core restored");

    a_release_pulse: assert property (@(posedge mclk) disable iff (!resetn)
        irq_release |=> !irq_release)
        else $error("interrupt release longer than one cycle");
endmodule

/* pmu_core_model.sv */
// partner model: power unit and core answering a wake request
module pmu_core_model
    import wakeup_pkg::*;
(
    input  wire logic                 mclk,
    input  wire logic                 resetn,
    input  wire logic                 sleep_go,
    input  wire logic                 select_in,
    input  wire logic                 debugger_in,
    input  wire logic [3:0]           lag,
    input  wakeup_pkg::pmu_ctrl_t     pmu_ctrl,
    output wakeup_pkg::core_status_t  core_status
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       sleeping_reg;
    logic       done_reg;
    logic [3:0] wait_reg;
    assign core_status = {sleeping_reg, select_in, debugger_in, done_reg};
    always @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            sleeping_reg <= 1'b0;
            done_reg <= 1'b0;
            wait_reg <= 4'h0;
        end
        else if (done_reg)
            done_reg <= 1'b0;
        else if (pmu_ctrl.wake_request && wait_reg == lag)
        begin
            done_reg <= 1'b1;
            sleeping_reg <= 1'b0;
            wait_reg <= 4'h0;
        end
        else if (pmu_ctrl.wake_request)
            wait_reg <= wait_reg + 4'h1;
        else
            sleeping_reg <= sleep_go;
    end
endmodule

/* deep_sleep_wakeup_detector_tb.sv */
// testbench for the deep sleep wakeup detector
module deep_sleep_wakeup_detector_tb;
    import wakeup_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic         mclk = 1'b0;
    logic         resetn = 1'b0;
    logic [7:0]   irq = 8'h00;
    logic         sleep_go = 1'b0;
    logic         select_in = 1'b0;
    logic         debugger_in = 1'b0;
    logic [3:0]   lag = 4'h1;
    core_status_t core_status;
    pmu_ctrl_t    pmu_ctrl;
    logic         irq_release;
    int           fail_count = 0;
    int           total_checks = 0;
    int           cycles = 0;
    deep_sleep_wakeup_detector i_deep_sleep_wakeup_detector (.mclk(mclk), .resetn(resetn),
        .irq(irq), .core_status(core_status), .pmu_ctrl(pmu_ctrl), .irq_release(irq_release));
    pmu_core_model i_pmu_core_model (.mclk(mclk), .resetn(resetn), .sleep_go(sleep_go),
        .select_in(select_in), .debugger_in(debugger_in), .lag(lag), .pmu_ctrl(pmu_ctrl),
        .core_status(core_status));
    initial
    begin
        forever #10 mclk = ~mclk;
    end
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // hangs are cut short well beyond the expected run
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            fail_count++;
            end_of_test();
        end
    end
    task automatic chk_ctrl(string name, logic [4:0] exp, pmu_ctrl_t got);
        total_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic chk_bit(string name, logic [7:0] exp, logic [7:0] got);
        total_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic step();
        @(negedge mclk);
    endtask
    // deep sleep, wake by one line, count restore delay
    task automatic deep_wake(int bitn, logic [3:0] slow);
        int n;
        lag = slow;
        select_in = 1'b1;
        sleep_go = 1'b1;
        step();
        step();
        chk_ctrl("armed", 5'h17, pmu_ctrl);
        irq = 8'h01 << bitn;
        step();
        chk_ctrl("waking", 5'h0c, pmu_ctrl);
        irq = 8'h00;
        n = 0;
        while (!core_status.restore_done && n < 30)
        begin
            chk_bit("wake_held", 8'h01, {7'h00, pmu_ctrl.wake_request});
            step();
            n++;
        end
        sleep_go = 1'b0;
        step();
        chk_ctrl("restored", 5'h00, pmu_ctrl);
        n = 0;
        while (!irq_release && n < 40)
        begin
            step();
            n++;
        end
        chk_bit("restore_cycles", 8'(RESTORE_CYCLES), 8'(n));
        step();
        chk_bit("release_pulse", 8'h00, {7'h00, irq_release});
    endtask
    // sleep without arming: interrupt must not wake
    task automatic no_wake(logic sel, logic dbg);
        select_in = sel;
        debugger_in = dbg;
        sleep_go = 1'b1;
        step();
        step();
        chk_ctrl("not_armed", 5'h02, pmu_ctrl);
        irq = 8'h80;
        step();
        step();
        chk_ctrl("ignored_irq", 5'h02, pmu_ctrl);
        irq = 8'h00;
        sleep_go = 1'b0;
        debugger_in = 1'b0;
        step();
        step();
    endtask
    // armed, then debugger or select drop disarms before any interrupt
    task automatic disarm(logic dbg);
        select_in = 1'b1;
        sleep_go = 1'b1;
        step();
        step();
        chk_ctrl("armed_again", 5'h17, pmu_ctrl);
        debugger_in = dbg;
        select_in = dbg;
        step();
        chk_ctrl("disarmed", 5'h02, pmu_ctrl);
        irq = 8'h10;
        step();
        step();
        chk_ctrl("no_wake_after_disarm", 5'h02, pmu_ctrl);
        irq = 8'h00;
        sleep_go = 1'b0;
        select_in = 1'b0;
        debugger_in = 1'b0;
        step();
        step();
    endtask
    // reset in the middle of a wake drops every control at once
    task automatic reset_mid_wake();
        select_in = 1'b1;
        sleep_go = 1'b1;
        step();
        step();
        irq = 8'h04;
        step();
        chk_ctrl("wake_before_reset", 5'h0c, pmu_ctrl);
        irq = 8'h00;
        sleep_go = 1'b0;
        resetn = 1'b0;
        step();
        chk_ctrl("in_reset", 5'h00, pmu_ctrl);
        resetn = 1'b1;
        step();
        step();
        chk_ctrl("after_mid_reset", 5'h00, pmu_ctrl);
        chk_bit("release_after_reset", 8'h00, {7'h00, irq_release});
        select_in = 1'b0;
    endtask
    initial
    begin
        repeat (16) @(negedge mclk);
        resetn = 1'b1;
        step();
        chk_ctrl("after_reset", 5'h00, pmu_ctrl);
        deep_wake(0, 4'h1);
        deep_wake(7, 4'h6);
        no_wake(1'b0, 1'b0);
        no_wake(1'b1, 1'b1);
        disarm(1'b1);
        disarm(1'b0);
        reset_mid_wake();
        end_of_test();
    end
endmodule
